// ==== design/cnm_master_code.sv ====
// Priority encoder that forms the registered master state code.
`timescale 1ns/1ns
`default_nettype none
module cnm_master_code
  import cnm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic master_i,
  input wire logic any_slave_i,
  input wire logic cfg_dl_i,
  input wire logic cfg_err_i,
  input wire logic bus_off_i,
  input wire logic [6:0] own_id_i,
  input wire logic mem_err_i,
  input wire logic tx_full_i,
  input wire logic rx_full_i,
  output logic [7:0] code_o
);
  typedef struct packed {
    logic [7:0] code;
  } cnm_mc_st_t;

  cnm_mc_st_t st_q;
  cnm_mc_st_t st_d;
  logic id_bad;

  assign id_bad = (own_id_i < OWN_ID_MIN) || (own_id_i > OWN_ID_MAX);

  // The most severe condition wins when several are present.
  always_comb begin
    st_d = st_q;
    if (run_i) begin
      if (!master_i) begin
        st_d.code = CODE_OK;
      end else if (mem_err_i) begin
        st_d.code = CODE_F8;
      end else if (id_bad) begin
        st_d.code = CODE_F5;
      end else if (bus_off_i) begin
        st_d.code = CODE_F4;
      end else if (cfg_dl_i) begin
        st_d.code = CODE_F2;
      end else if (cfg_err_i) begin
        st_d.code = CODE_F3;
      end else if (tx_full_i) begin
        st_d.code = CODE_FB;
      end else if (rx_full_i) begin
        st_d.code = CODE_FC;
      end else if (!any_slave_i) begin
        st_d.code = CODE_F1;
      end else begin
        st_d.code = CODE_OK;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign code_o = st_q.code;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_not_master;
    run_i && !master_i |=> code_o == CODE_OK;
  endproperty
  a_not_master: assert property (p_not_master) else $error("master code not zero");

  property p_mem_err;
    run_i && master_i && mem_err_i |=> code_o == CODE_F8;
  endproperty
  a_mem_err: assert property (p_mem_err) else $error("memory error not shown");

  property p_bus_off;
    run_i && master_i && !mem_err_i && !id_bad && bus_off_i |=> code_o == CODE_F4;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus-off not shown");

  property p_no_slave;
    run_i && master_i && !mem_err_i && !id_bad && !bus_off_i && !cfg_dl_i
      && !cfg_err_i && !tx_full_i && !rx_full_i && !any_slave_i
      |=> code_o == CODE_F1;
  endproperty
  a_no_slave: assert property (p_no_slave) else $error("empty list not shown");
endmodule // cnm_master_code
`default_nettype wire

// ==== design/cnm_node_state_monitor.sv ====
// Node state monitor register bank with a classic Wishbone slave port.
//
// Function
// - As master, track slaves 1 to 64 with flags in four 16-bit words.
// - First flag word bit 0 is node 1 up to bit 15 node 16.
// - Flag clear while a configured node is normal, set when abnormal.
// - One error code register per node, node n at base plus 4*(n-1) bytes.
// - Error code reads zero when node has no error or is unconfigured.
// - Emergency message from a slave writes code E0.
// - Returned process-data length mismatch reports code E1.
// - Expected process-data objects not received report code E2.
// - Service-data download failure gives E3, process-data setup failure E4.
// - Key parameters showing a mismatched slave report code E5.
// - Configured slave absent from the network reports code E6.
// - Error-control supervision timeout reports code E7.
// - Slave identifier equal to the master identifier reports code E8.
// - Master state reads F1 when the node list holds no slave.
// - Master state F2 during configuration download, F3 on its failure.
// - Master state F4 when the controller goes bus-off.
// - Master state F5 when own settings are invalid, address outside 1-127.
// - Master state F8 on an internal memory error.
// - Master state FB on full transmit buffer, FC on full receive buffer.
// - Active baud rate is readable in units of one kbit/s.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module cnm_node_state_monitor
  import cnm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [63:0] node_cfg_i,
  input wire logic evt_vld_i,
  input wire logic [6:0] evt_node_i,
  input wire cnm_evt_t evt_kind_i,
  input wire logic [15:0] baud_kbps_i,
  input wire logic cfg_dl_i,
  input wire logic cfg_err_i,
  input wire logic bus_off_i,
  input wire logic [6:0] own_id_i,
  input wire logic mem_err_i,
  input wire logic tx_full_i,
  input wire logic rx_full_i
);
  typedef struct packed {
    logic [1:0] ctrl;
    logic [15:0] baud;
    logic [NODES-1:0][7:0] err;
    logic [NODES-1:0] flag;
    logic ack;
    logic [31:0] dat;
  } cnm_st_t;

  cnm_st_t st_q;
  cnm_st_t st_d;
  logic [7:0] mcode;
  logic bus_req;
  logic node_ok;
  logic [5:0] evt_idx;
  logic evt_hit;
  logic run;

  // Maps a reported event kind onto the code shown for that node.
  function automatic logic [7:0] code_of(input cnm_evt_t k);
    logic [7:0] c;
    c = CODE_OK;
    case (k)
      EVT_EMCY: c = CODE_E0;
      EVT_PDO_LEN: c = CODE_E1;
      EVT_PDO_MISS: c = CODE_E2;
      EVT_SDO_FAIL: c = CODE_E3;
      EVT_PDO_CFG: c = CODE_E4;
      EVT_KEY_PARAM: c = CODE_E5;
      EVT_ABSENT: c = CODE_E6;
      EVT_GUARD_TO: c = CODE_E7;
      EVT_DUP_ID: c = CODE_E8;
      default: c = CODE_OK;
    endcase
    return c;
  endfunction

  // Read decode; unmapped addresses answer with zero.
  function automatic logic [31:0] reg_rd(input logic [8:0] a, input cnm_st_t s,
                                         input logic [7:0] mc);
    logic [31:0] r;
    r = '0;
    if (a[ERR_SEL_BIT]) begin
      r = {24'h00_0000, s.err[a[7:2]]};
    end else begin
      case (a)
        OFF_VERSION: r = {16'h0000, PROTO_VERSION};
        OFF_BAUD: r = {16'h0000, s.baud};
        OFF_MSTATE: r = {24'h00_0000, mc};
        OFF_FLAGS_1_16: r = {16'h0000, s.flag[15:0]};
        OFF_FLAGS_17_32: r = {16'h0000, s.flag[31:16]};
        OFF_FLAGS_33_48: r = {16'h0000, s.flag[47:32]};
        OFF_FLAGS_49_64: r = {16'h0000, s.flag[63:48]};
        OFF_CTRL: r = {30'h0000_0000, s.ctrl};
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i && !st_q.ack;
  assign run = st_q.ctrl[CTRL_EN_BIT];
  assign node_ok = (evt_node_i >= NODE_FIRST) && (evt_node_i <= NODE_LAST);
  assign evt_idx = 6'(evt_node_i - NODE_FIRST);
  assign evt_hit = run && evt_vld_i && node_ok && node_cfg_i[evt_idx];

  cnm_master_code u_mcode (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .master_i(st_q.ctrl[CTRL_MST_BIT]),
    .any_slave_i(|node_cfg_i),
    .cfg_dl_i(cfg_dl_i),
    .cfg_err_i(cfg_err_i),
    .bus_off_i(bus_off_i),
    .own_id_i(own_id_i),
    .mem_err_i(mem_err_i),
    .tx_full_i(tx_full_i),
    .rx_full_i(rx_full_i),
    .code_o(mcode)
  );

  always_comb begin
    st_d = st_q;
    st_d.ack = bus_req;
    st_d.dat = '0;
    if (bus_req && !wb_we_i) begin
      st_d.dat = reg_rd(wb_adr_i, st_q, mcode);
    end
    // Only the control word takes writes; status words ignore them.
    if (bus_req && wb_we_i && wb_adr_i == OFF_CTRL && wb_sel_i[0]) begin
      st_d.ctrl = wb_dat_i[1:0];
    end
    if (run) begin
      st_d.baud = baud_kbps_i;
      if (evt_hit) begin
        st_d.err[evt_idx] = code_of(evt_kind_i);
      end
      for (int i = 0; i < NODES; i++) begin
        if (!node_cfg_i[i]) begin
          st_d.err[i] = CODE_OK;
        end
        st_d.flag[i] = node_cfg_i[i] && (st_d.err[i] != CODE_OK);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.ctrl <= CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.dat;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_rd_req(logic [8:0] a);
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == a;
  endsequence

  property p_ack_once;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not one cycle");

  property p_evt_code;
    evt_hit |=> st_q.err[$past(evt_idx)] == code_of($past(evt_kind_i));
  endproperty
  a_evt_code: assert property (p_evt_code) else $error("node code wrong");

  property p_emcy;
    evt_hit && evt_kind_i == EVT_EMCY |=> st_q.err[$past(evt_idx)] == CODE_E0;
  endproperty
  a_emcy: assert property (p_emcy) else $error("emergency code wrong");

  property p_absent;
    evt_hit && evt_kind_i == EVT_ABSENT |=> st_q.err[$past(evt_idx)] == CODE_E6;
  endproperty
  a_absent: assert property (p_absent) else $error("absent code wrong");

  property p_flag_set;
    evt_hit && evt_kind_i != EVT_OK && node_cfg_i[evt_idx]
      |=> st_q.flag[$past(evt_idx)];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_clr;
    evt_hit && evt_kind_i == EVT_OK
      |=> !st_q.flag[$past(evt_idx)] && st_q.err[$past(evt_idx)] == CODE_OK;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_rd_flags;
    s_rd_req(OFF_FLAGS_1_16) |=> wb_dat_o == {16'h0000, $past(st_q.flag[15:0])};
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag word wrong");

  property p_rd_baud;
    s_rd_req(OFF_BAUD) |=> wb_ack_o && wb_dat_o == {16'h0000, $past(st_q.baud)};
  endproperty
  a_rd_baud: assert property (p_rd_baud) else $error("baud word wrong");

  property p_ro;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == OFF_BAUD && !run
      |=> st_q.baud == $past(st_q.baud);
  endproperty
  a_ro: assert property (p_ro) else $error("status word written");

  sequence s_wr_req(logic [8:0] a);
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == a;
  endsequence

  property p_pdo_len;
    evt_hit && evt_kind_i == EVT_PDO_LEN |=> st_q.err[$past(evt_idx)] == CODE_E1;
  endproperty
  a_pdo_len: assert property (p_pdo_len) else $error("length code wrong");

  property p_pdo_miss;
    evt_hit && evt_kind_i == EVT_PDO_MISS |=> st_q.err[$past(evt_idx)] == CODE_E2;
  endproperty
  a_pdo_miss: assert property (p_pdo_miss) else $error("missing data code wrong");

  property p_sdo_fail;
    evt_hit && evt_kind_i == EVT_SDO_FAIL |=> st_q.err[$past(evt_idx)] == CODE_E3;
  endproperty
  a_sdo_fail: assert property (p_sdo_fail) else $error("download code wrong");

  property p_pdo_cfg;
    evt_hit && evt_kind_i == EVT_PDO_CFG |=> st_q.err[$past(evt_idx)] == CODE_E4;
  endproperty
  a_pdo_cfg: assert property (p_pdo_cfg) else $error("setup code wrong");

  property p_key_param;
    evt_hit && evt_kind_i == EVT_KEY_PARAM |=> st_q.err[$past(evt_idx)] == CODE_E5;
  endproperty
  a_key_param: assert property (p_key_param) else $error("key code wrong");

  property p_guard_to;
    evt_hit && evt_kind_i == EVT_GUARD_TO |=> st_q.err[$past(evt_idx)] == CODE_E7;
  endproperty
  a_guard_to: assert property (p_guard_to) else $error("timeout code wrong");

  property p_dup_id;
    evt_hit && evt_kind_i == EVT_DUP_ID |=> st_q.err[$past(evt_idx)] == CODE_E8;
  endproperty
  a_dup_id: assert property (p_dup_id) else $error("duplicate id code wrong");

  property p_ctrl_wr;
    s_wr_req(OFF_CTRL) ##0 wb_sel_i[0] |=> st_q.ctrl == $past(wb_dat_i[1:0]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  property p_sel_keep;
    s_wr_req(OFF_CTRL) ##0 !wb_sel_i[0] |=> st_q.ctrl == $past(st_q.ctrl);
  endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("masked write landed");

  property p_ro_any;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i != OFF_CTRL
      |=> st_q.ctrl == $past(st_q.ctrl);
  endproperty
  a_ro_any: assert property (p_ro_any) else $error("status write landed");

  property p_freeze;
    !run |=> st_q.err == $past(st_q.err) && st_q.flag == $past(st_q.flag)
      && st_q.baud == $past(st_q.baud);
  endproperty
  a_freeze: assert property (p_freeze) else $error("status moved while disabled");

  property p_baud_track;
    run |=> st_q.baud == $past(baud_kbps_i);
  endproperty
  a_baud_track: assert property (p_baud_track) else $error("baud not tracked");

  property p_rd_version;
    s_rd_req(OFF_VERSION) |=> wb_dat_o == {16'h0000, PROTO_VERSION};
  endproperty
  a_rd_version: assert property (p_rd_version) else $error("version word wrong");

  property p_rd_mstate;
    s_rd_req(OFF_MSTATE) |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(mcode)};
  endproperty
  a_rd_mstate: assert property (p_rd_mstate) else $error("master word wrong");

  property p_rd_err;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i[ERR_SEL_BIT]
      |=> wb_dat_o == {24'h00_0000, $past(st_q.err[wb_adr_i[7:2]])};
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("node code word wrong");

  property p_rd_flags2;
    s_rd_req(OFF_FLAGS_17_32) |=> wb_dat_o == {16'h0000, $past(st_q.flag[31:16])};
  endproperty
  a_rd_flags2: assert property (p_rd_flags2) else $error("flag word 2 wrong");

  property p_rd_flags3;
    s_rd_req(OFF_FLAGS_33_48) |=> wb_dat_o == {16'h0000, $past(st_q.flag[47:32])};
  endproperty
  a_rd_flags3: assert property (p_rd_flags3) else $error("flag word 3 wrong");

  property p_rd_flags4;
    s_rd_req(OFF_FLAGS_49_64) |=> wb_dat_o == {16'h0000, $past(st_q.flag[63:48])};
  endproperty
  a_rd_flags4: assert property (p_rd_flags4) else $error("flag word 4 wrong");

  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

  property p_ack_needs_req;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");

  generate
    for (genvar g = 0; g < NODES; g++) begin : g_node
      property p_uncfg;
        run && !node_cfg_i[g] |=> st_q.err[g] == CODE_OK && !st_q.flag[g];
      endproperty
      a_uncfg: assert property (p_uncfg) else $error("unconfigured node shows error");
      property p_flag_eq;
        run && node_cfg_i[g] |=> st_q.flag[g] == (st_q.err[g] != CODE_OK);
      endproperty
      a_flag_eq: assert property (p_flag_eq) else $error("flag disagrees with code");
    end
  endgenerate
endmodule // cnm_node_state_monitor
`default_nettype wire

// ==== shared/cnm_pkg.sv ====
// Register map, codes and event kinds for the node state monitor.
`default_nettype none
package cnm_pkg;
  localparam int NODES = 64;
  localparam int FLAG_W = 16;
  // Byte addresses on the register bus.
  localparam logic [8:0] OFF_VERSION = 9'h000;
  localparam logic [8:0] OFF_BAUD = 9'h004;
  localparam logic [8:0] OFF_MSTATE = 9'h008;
  localparam logic [8:0] OFF_FLAGS_1_16 = 9'h00C;
  localparam logic [8:0] OFF_FLAGS_17_32 = 9'h010;
  localparam logic [8:0] OFF_FLAGS_33_48 = 9'h014;
  localparam logic [8:0] OFF_FLAGS_49_64 = 9'h018;
  localparam logic [8:0] OFF_CTRL = 9'h020;
  localparam logic [8:0] OFF_ERR_BASE = 9'h100;
  localparam int ERR_SEL_BIT = 8;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MST_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // Value is arbitrary.
  localparam logic [15:0] PROTO_VERSION = 16'h0001;
  // Node codes.
  localparam logic [7:0] CODE_OK = 8'h00;
  localparam logic [7:0] CODE_E0 = 8'hE0;
  localparam logic [7:0] CODE_E1 = 8'hE1;
  localparam logic [7:0] CODE_E2 = 8'hE2;
  localparam logic [7:0] CODE_E3 = 8'hE3;
  localparam logic [7:0] CODE_E4 = 8'hE4;
  localparam logic [7:0] CODE_E5 = 8'hE5;
  localparam logic [7:0] CODE_E6 = 8'hE6;
  localparam logic [7:0] CODE_E7 = 8'hE7;
  localparam logic [7:0] CODE_E8 = 8'hE8;
  // Master codes.
  localparam logic [7:0] CODE_F1 = 8'hF1;
  localparam logic [7:0] CODE_F2 = 8'hF2;
  localparam logic [7:0] CODE_F3 = 8'hF3;
  localparam logic [7:0] CODE_F4 = 8'hF4;
  localparam logic [7:0] CODE_F5 = 8'hF5;
  localparam logic [7:0] CODE_F8 = 8'hF8;
  localparam logic [7:0] CODE_FB = 8'hFB;
  localparam logic [7:0] CODE_FC = 8'hFC;
  localparam logic [6:0] NODE_FIRST = 7'h01;
  localparam logic [6:0] NODE_LAST = 7'h40;
  localparam logic [6:0] OWN_ID_MIN = 7'h01;
  localparam logic [6:0] OWN_ID_MAX = 7'h7F;
  typedef enum logic [3:0] {
    EVT_OK, EVT_EMCY, EVT_PDO_LEN, EVT_PDO_MISS, EVT_SDO_FAIL,
    EVT_PDO_CFG, EVT_KEY_PARAM, EVT_ABSENT, EVT_GUARD_TO, EVT_DUP_ID
  } cnm_evt_t;
endpackage
`default_nettype wire

// ==== verif/cnm_node_state_monitor_tb.sv ====
// Self-checking bench for the node state monitor register bank.
`timescale 1ns/1ns
`default_nettype none
module cnm_node_state_monitor_tb
  import cnm_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [8:0] adr = 9'h000;
  logic [3:0] sel = 4'h0;
  logic [3:0] sel_w = 4'hF;
  logic [31:0] dat_w = 32'h0000_0000;
  logic [31:0] dat_r;
  logic ack;
  logic dl = 1'b0, cerr = 1'b0, boff = 1'b0, merr = 1'b0, txf = 1'b0, rxf = 1'b0;
  logic [6:0] own_id = 7'h7F;
  logic [63:0] cfg;
  logic [15:0] baud;
  logic evt_vld;
  logic [6:0] evt_node;
  cnm_evt_t evt_kind;
  int fail_count = 0;
  int checked = 0;
  int nodes [0:8] = '{1, 16, 17, 32, 33, 48, 49, 64, 2};
  logic [7:0] ecode [0:9] = '{CODE_OK, CODE_E0, CODE_E1, CODE_E2, CODE_E3, CODE_E4,
                              CODE_E5, CODE_E6, CODE_E7, CODE_E8};
  logic [7:0] mexp [0:7] = '{CODE_F8, CODE_F5, CODE_F4, CODE_F2, CODE_F3, CODE_FB,
                             CODE_FC, CODE_F1};
  logic [63:0] flags = 64'h0000_0000_0000_0000;
  logic [7:0] cond;

  always #4 clk_i = ~clk_i;

  cnm_slave_model slv (.clk_i(clk_i), .node_cfg_o(cfg), .baud_kbps_o(baud),
    .evt_vld_o(evt_vld), .evt_node_o(evt_node), .evt_kind_o(evt_kind));

  cnm_node_state_monitor uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .node_cfg_i(cfg), .evt_vld_i(evt_vld), .evt_node_i(evt_node),
    .evt_kind_i(evt_kind), .baud_kbps_i(baud), .cfg_dl_i(dl), .cfg_err_i(cerr),
    .bus_off_i(boff), .own_id_i(own_id), .mem_err_i(merr), .tx_full_i(txf),
    .rx_full_i(rxf));

  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; entered just after a rising edge, leaves one idle cycle behind.
  task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= sel_w;
    dat_w <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      chk({31'h0000_0000, ack}, 32'h0000_0001);
      tally_and_finish();
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  function automatic logic [8:0] ea(input int n);
    return OFF_ERR_BASE + 9'(4 * (n - 1));
  endfunction

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFF_VERSION, {16'h0000, PROTO_VERSION});
    rd(OFF_MSTATE, 32'h0000_0000);
    wr(OFF_VERSION, 32'hFFFF_FFFF);
    wr(OFF_MSTATE, 32'hFFFF_FFFF);
    rd(OFF_VERSION, {16'h0000, PROTO_VERSION});
    rd(OFF_MSTATE, 32'h0000_0000);
    rd(9'h030, 32'h0000_0000);
    $display("Test access done");
    slv.set_baud(16'h03E8);
    slv.set_cfg(64'hFFFF_FFFF_FFFF_FFEF);
    wr(OFF_CTRL, 32'h0000_0003);
    rd(OFF_CTRL, 32'h0000_0003);
    sel_w = 4'hE;
    wr(OFF_CTRL, 32'h0000_0000);
    sel_w = 4'hF;
    rd(OFF_CTRL, 32'h0000_0003);
    rd(OFF_BAUD, 32'h0000_03E8);
    for (int k = 1; k < 10; k++) begin
      slv.emit(7'(nodes[k-1]), cnm_evt_t'(k));
      flags[nodes[k-1]-1] = 1'b1;
      rd(ea(nodes[k-1]), {24'h00_0000, ecode[k]});
    end
    slv.emit(7'h01, EVT_OK);
    flags[0] = 1'b0;
    rd(ea(1), 32'h0000_0000);
    slv.emit(7'h05, EVT_ABSENT);
    rd(ea(5), 32'h0000_0000);
    slv.emit(7'h00, EVT_EMCY);
    rd(ea(1), 32'h0000_0000);
    slv.set_cfg(64'h7FFF_FFFF_FFFF_FFEF);
    @(posedge clk_i);
    flags[63] = 1'b0;
    rd(ea(64), 32'h0000_0000);
    for (int w = 0; w < 4; w++) begin
      rd(OFF_FLAGS_1_16 + 9'(4 * w), {16'h0000, flags[16*w +: 16]});
    end
    $display("Test node codes done");
    wr(OFF_CTRL, 32'h0000_0000);
    slv.set_baud(16'h00FA);
    slv.emit(7'h02, EVT_EMCY);
    rd(OFF_BAUD, 32'h0000_03E8);
    rd(ea(2), {24'h00_0000, CODE_E8});
    wr(OFF_CTRL, 32'h0000_0003);
    rd(OFF_BAUD, 32'h0000_00FA);
    $display("Test freeze done");
    rd(OFF_MSTATE, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      cond = 8'hFF >> i;
      merr <= cond[7];
      own_id <= cond[6] ? 7'h00 : 7'h7F;
      boff <= cond[5];
      dl <= cond[4];
      cerr <= cond[3];
      txf <= cond[2];
      rxf <= cond[1];
      slv.set_cfg(cond[0] ? 64'h0000_0000_0000_0000 : 64'h0000_0000_0000_0001);
      @(posedge clk_i);
      rd(OFF_MSTATE, {24'h00_0000, mexp[i]});
    end
    merr <= 1'b0;
    own_id <= 7'h01;
    rxf <= 1'b0;
    slv.set_cfg(64'h8000_0000_0000_0000);
    @(posedge clk_i);
    rd(OFF_MSTATE, 32'h0000_0000);
    merr <= 1'b1;
    wr(OFF_CTRL, 32'h0000_0001);
    rd(OFF_MSTATE, 32'h0000_0000);
    $display("Test master state done");
    tally_and_finish();
  end
endmodule // cnm_node_state_monitor_tb
`default_nettype wire

// ==== verif/cnm_slave_model.sv ====
// Behavioural model of the slave nodes: node list, baud rate and node events.
`timescale 1ns/1ns
`default_nettype none
module cnm_slave_model
  import cnm_pkg::*;
(
  input wire logic clk_i,
  output logic [63:0] node_cfg_o,
  output logic [15:0] baud_kbps_o,
  output logic evt_vld_o,
  output logic [6:0] evt_node_o,
  output cnm_evt_t evt_kind_o
);
  initial begin
    node_cfg_o = 64'h0000_0000_0000_0000;
    baud_kbps_o = 16'h0000;
    evt_vld_o = 1'b0;
    evt_node_o = 7'h00;
    evt_kind_o = EVT_OK;
  end
  task automatic set_cfg(input logic [63:0] v);
    node_cfg_o <= v;
  endtask
  task automatic set_baud(input logic [15:0] v);
    baud_kbps_o <= v;
  endtask
  // Node and kind are scrambled once the strobe drops, so stale values never match.
  task automatic emit(input logic [6:0] n, input cnm_evt_t k);
    evt_vld_o <= 1'b1;
    evt_node_o <= n;
    evt_kind_o <= k;
    @(posedge clk_i);
    evt_vld_o <= 1'b0;
    evt_node_o <= ~n;
    evt_kind_o <= cnm_evt_t'(~k);
  endtask
endmodule // cnm_slave_model
`default_nettype wire
